// ===== inc/riu_pkg.sv
// Constants shared by the reader interrupt flag and mask unit
package riu_pkg;

  localparam int unsigned DATA_W     = 32;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned REG_W      = 8;
  localparam int unsigned IDX_W      = 6;
  localparam int unsigned FIFO_CNT_W = 7;

  // Register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_OP_CTRL     = 6'h02;
  localparam logic [IDX_W-1:0] IDX_MAIN_MASK   = 6'h14;
  localparam logic [IDX_W-1:0] IDX_TIMER_MASK  = 6'h15;
  localparam logic [IDX_W-1:0] IDX_ERR_MASK    = 6'h16;
  localparam logic [IDX_W-1:0] IDX_MAIN_FLAGS  = 6'h17;
  localparam logic [IDX_W-1:0] IDX_TIMER_FLAGS = 6'h18;
  localparam logic [IDX_W-1:0] IDX_ERR_FLAGS   = 6'h19;
  localparam logic [IDX_W-1:0] IDX_COMMAND     = 6'h30;

  localparam logic [REG_W-1:0]  MASK_RST        = 8'h00;
  localparam logic [REG_W-1:0]  FLAG_RST        = 8'h00;
  localparam logic [REG_W-1:0]  OP_CTRL_RST     = 8'h00;
  localparam logic [REG_W-1:0]  MAIN_MASK_USED  = 8'hfc;
  localparam logic [REG_W-1:0]  MAIN_FLAG_LATCH = 8'hfc;
  localparam logic [REG_W-1:0]  CMD_SET_DEFAULT = 8'hc1;
  localparam logic [DATA_W-1:0] RDATA_RST       = 32'h0000_0000;

  // Summary register bit positions
  localparam int unsigned MAIN_OSC = 7;
  localparam int unsigned MAIN_WL  = 6;
  localparam int unsigned MAIN_RXS = 5;
  localparam int unsigned MAIN_RXE = 4;
  localparam int unsigned MAIN_TXE = 3;
  localparam int unsigned MAIN_COL = 2;
  localparam int unsigned MAIN_TIM = 1;
  localparam int unsigned MAIN_ERR = 0;

  // Timer and field register bit positions
  localparam int unsigned TF_DCT  = 7;
  localparam int unsigned TF_NRE  = 6;
  localparam int unsigned TF_GPE  = 5;
  localparam int unsigned TF_EON  = 4;
  localparam int unsigned TF_EOF  = 3;
  localparam int unsigned TF_CAC  = 2;
  localparam int unsigned TF_CAT  = 1;
  localparam int unsigned TF_NFCT = 0;

  localparam int unsigned OPC_EN = 7;

  // FIFO water levels
  localparam logic [FIFO_CNT_W-1:0] WL_FULL  = 7'h50;
  localparam logic [FIFO_CNT_W-1:0] WL_EMPTY = 7'h10;

  // Guard time after own field switch-on
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned GUARD_TIME_US = 5000;
  localparam int unsigned GUARD_CYC_DEF =
    (GUARD_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GUARD_CNT_W = 20;

endpackage : riu_pkg

// ===== inc/riu_flag_if.sv
// Set, clear and flag signals between the unit and one flag bank
`timescale 1ns/1ps
`default_nettype none
interface riu_flag_if;
  import riu_pkg::*;
  logic [REG_W-1:0] set;
  logic [REG_W-1:0] clr;
  logic             sdef;
  logic [REG_W-1:0] flags;

  modport bank (input set, input clr, input sdef, output flags);
  modport ctrl (output set, output clr, output sdef, input flags);
endinterface : riu_flag_if
`default_nettype wire

// ===== logic/riu_flag_bank.sv
// Eight sticky event flags with read clear and set-default clear
`timescale 1ns/1ps
`default_nettype none
module riu_flag_bank
  import riu_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  riu_flag_if.bank  fl
);

  logic [REG_W-1:0] flags_ff;
  logic [REG_W-1:0] nxt_flags;

  // Only bits that were returned by the read are cleared; a set wins
  always_comb begin
    if (fl.sdef) begin
      nxt_flags = FLAG_RST;
    end else begin
      nxt_flags = (flags_ff & ~fl.clr) | fl.set; // [RULE19]
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flags_ff <= FLAG_RST;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign fl.flags = flags_ff;

endmodule : riu_flag_bank
`default_nettype wire

// ===== logic/riu_guard_timer.sv
// Guard time counter started when the own field is switched on
`timescale 1ns/1ps
`default_nettype none
module riu_guard_timer
  import riu_pkg::*;
#(
  parameter int unsigned GUARD_CYC = GUARD_CYC_DEF
)(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic start_i,
  input  wire logic cancel_i,
  output logic      done_o
);

  typedef enum logic {GT_IDLE, GT_RUN} riu_gt_state_type;

  localparam logic [GUARD_CNT_W-1:0] CNT_LAST = GUARD_CNT_W'(GUARD_CYC - 1);
  localparam logic [GUARD_CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [GUARD_CNT_W-1:0] CNT_ONE  = GUARD_CNT_W'(1);

  riu_gt_state_type       state_ff;
  riu_gt_state_type       nxt_state;
  logic [GUARD_CNT_W-1:0] cnt_ff;
  logic [GUARD_CNT_W-1:0] nxt_cnt;
  logic                   done_ff;
  logic                   nxt_done;

  // A new switch-on restarts the wait so the flag never comes early
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_done  = 1'b0;
    if (cancel_i) begin
      nxt_state = GT_IDLE;
      nxt_cnt   = CNT_ZERO;
    end else if (start_i) begin
      nxt_state = GT_RUN;
      nxt_cnt   = CNT_ZERO;
    end else begin
      unique case (state_ff)
        GT_IDLE: begin
          nxt_cnt = CNT_ZERO;
        end
        GT_RUN: begin
          if (cnt_ff == CNT_LAST) begin
            nxt_state = GT_IDLE;
            nxt_done  = 1'b1; // [RULE14]
          end else begin
            nxt_cnt = cnt_ff + CNT_ONE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_ff <= GT_IDLE;
      cnt_ff   <= CNT_ZERO;
      done_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      done_ff  <= nxt_done;
    end
  end

  assign done_o = done_ff;

endmodule : riu_guard_timer
`default_nettype wire

// ===== logic/riu_irq_unit.sv
// Interrupt flag and mask unit of a contactless reader front end
//
// Behaviour
// RULE1 - Error/wake-up mask register holds eight masks; 1 suppresses that source.
// RULE2 - Error/wake-up masks read zero after reset and after set-default.
// RULE3 - Summary register: osc, water level, rx start/end, tx end, collision, two groups.
// RULE4 - Oscillator flag sets when the enabled oscillator becomes stable.
// RULE5 - While receiving, water-level flag rises when FIFO is nearly full.
// RULE6 - While transmitting, water-level flag rises when FIFO is nearly empty.
// RULE7 - Summary bit 1 shows a pending timer/field event.
// RULE8 - Summary bit 0 shows a pending error or wake-up event.
// RULE9 - Reading the summary clears bits 7 to 2, never the group bits.
// RULE10 - Group bits clear only by reading their detail register, which clears too. Here masking the detail flag also drops them.
// RULE11 - Summary and timer/field flags clear at reset and set-default.
// RULE12 - Timer/field register: command, timers, field on/off, collision, guard, bit rate.
// RULE13 - Collision flag sets when external field appears during collision avoidance.
// RULE14 - Guard flag sets only after the minimum guard time following field-on.
// RULE15 - Main mask register holds six masks in bits 7..2; resets to zero.
// RULE16 - Timer/field mask register, one bit per flag; 1 masks; resets zero.
// RULE17 - Error/wake-up flag register, eight sources; cleared at reset.
// RULE18 - Interrupt output stays high while any unmasked flag is pending.
// RULE19 - An event in the cycle of a clearing read stays latched.
// RULE20 - Controller reads summary first, then detail registers for set groups.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module riu_irq_unit
  import riu_pkg::*;
#(
  parameter int unsigned GUARD_CYC = GUARD_CYC_DEF
)(
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [ADDR_W-1:0]     paddr_i,
  input  wire logic [DATA_W-1:0]     pwdata_i,
  output logic      [DATA_W-1:0]     prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  input  wire logic                  osc_stable_i,
  input  wire logic                  rx_active_i,
  input  wire logic                  tx_active_i,
  input  wire logic [FIFO_CNT_W-1:0] fifo_count_i,
  input  wire logic                  rx_start_i,
  input  wire logic                  rx_end_i,
  input  wire logic                  tx_end_i,
  input  wire logic                  bit_col_i,
  input  wire logic                  cmd_done_i,
  input  wire logic                  nrt_expire_i,
  input  wire logic                  gpt_expire_i,
  input  wire logic                  ext_field_i,
  input  wire logic                  ca_active_i,
  input  wire logic                  ca_field_on_i,
  input  wire logic                  bitrate_det_i,
  input  wire logic [REG_W-1:0]      err_wake_evt_i,
  output logic                       osc_en_o,
  output logic                       set_default_o,
  output logic                       irq_o
);

  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [IDX_W-1:0]  idx);
    addr_hit = (addr == {idx, 2'b00});
  endfunction : addr_hit

  function automatic logic [DATA_W-1:0] word(input logic [REG_W-1:0] val);
    word = {{(DATA_W - REG_W){1'b0}}, val};
  endfunction : word

  riu_flag_if main_fl ();
  riu_flag_if tf_fl ();
  riu_flag_if err_fl ();

  logic [DATA_W-1:0] prdata_ff;
  logic [DATA_W-1:0] nxt_prdata;
  logic              pready_ff;
  logic              nxt_pready;
  logic              pslverr_ff;
  logic              nxt_pslverr;
  logic [REG_W-1:0]  main_mask_ff;
  logic [REG_W-1:0]  nxt_main_mask;
  logic [REG_W-1:0]  tf_mask_ff;
  logic [REG_W-1:0]  nxt_tf_mask;
  logic [REG_W-1:0]  err_mask_ff;
  logic [REG_W-1:0]  nxt_err_mask;
  logic [REG_W-1:0]  op_ctrl_ff;
  logic [REG_W-1:0]  nxt_op_ctrl;
  logic              sdef_ff;
  logic              nxt_sdef;
  logic [REG_W-1:0]  snap_main_ff;
  logic [REG_W-1:0]  nxt_snap_main;
  logic [REG_W-1:0]  snap_tf_ff;
  logic [REG_W-1:0]  nxt_snap_tf;
  logic [REG_W-1:0]  snap_err_ff;
  logic [REG_W-1:0]  nxt_snap_err;
  logic              osc_prev_ff;
  logic              wl_prev_ff;
  logic              field_prev_ff;
  logic              cac_prev_ff;
  logic              irq_ff;
  logic              nxt_irq;

  logic              setup;
  logic              access_done;
  logic              wr_done;
  logic              hit_any;
  logic              wl_cond;
  logic              cac_cond;
  logic              guard_done;
  logic              grp_tim;
  logic              grp_err;
  logic [REG_W-1:0]  summary;
  logic [REG_W-1:0]  wr_byte;

  riu_flag_bank u_main_bank (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .fl      (main_fl.bank)
  );

  riu_flag_bank u_tf_bank (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .fl      (tf_fl.bank)
  );

  riu_flag_bank u_err_bank (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .fl      (err_fl.bank)
  );

  riu_guard_timer #(
    .GUARD_CYC (GUARD_CYC)
  ) u_guard (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .start_i  (ca_field_on_i),
    .cancel_i (sdef_ff),
    .done_o   (guard_done)
  );

  // Bus phase decode; the slave answers one cycle after setup
  assign setup       = psel_i & ~penable_i;
  assign access_done = psel_i & penable_i & pready_ff;
  assign wr_done     = access_done & pwrite_i;
  assign wr_byte     = pwdata_i[REG_W-1:0];

  assign hit_any = addr_hit(paddr_i, IDX_OP_CTRL)     |
                   addr_hit(paddr_i, IDX_MAIN_MASK)   |
                   addr_hit(paddr_i, IDX_TIMER_MASK)  |
                   addr_hit(paddr_i, IDX_ERR_MASK)    |
                   addr_hit(paddr_i, IDX_MAIN_FLAGS)  |
                   addr_hit(paddr_i, IDX_TIMER_FLAGS) |
                   addr_hit(paddr_i, IDX_ERR_FLAGS)   |
                   addr_hit(paddr_i, IDX_COMMAND);

  // Group bits follow the unmasked detail flags, so reading the detail
  // register, masking the flag or set-default drops them
  assign grp_tim = |(tf_fl.flags & ~tf_mask_ff);   // [RULE7] [RULE10]
  assign grp_err = |(err_fl.flags & ~err_mask_ff); // [RULE8] [RULE10]

  always_comb begin
    summary           = main_fl.flags & MAIN_FLAG_LATCH; // [RULE3]
    summary[MAIN_TIM] = grp_tim;
    summary[MAIN_ERR] = grp_err;
  end

  // Read data is captured in setup and stands through the access phase
  always_comb begin
    nxt_pready  = setup;
    nxt_pslverr = setup & ~hit_any;
    nxt_prdata  = prdata_ff;
    if (setup) begin
      nxt_prdata = RDATA_RST;
      if (!pwrite_i) begin
        if (addr_hit(paddr_i, IDX_OP_CTRL)) begin
          nxt_prdata = word(op_ctrl_ff);
        end
        if (addr_hit(paddr_i, IDX_MAIN_MASK)) begin
          nxt_prdata = word(main_mask_ff);
        end
        if (addr_hit(paddr_i, IDX_TIMER_MASK)) begin
          nxt_prdata = word(tf_mask_ff);
        end
        if (addr_hit(paddr_i, IDX_ERR_MASK)) begin
          nxt_prdata = word(err_mask_ff);
        end
        if (addr_hit(paddr_i, IDX_MAIN_FLAGS)) begin
          nxt_prdata = word(summary);
        end
        if (addr_hit(paddr_i, IDX_TIMER_FLAGS)) begin
          nxt_prdata = word(tf_fl.flags);
        end
        if (addr_hit(paddr_i, IDX_ERR_FLAGS)) begin
          nxt_prdata = word(err_fl.flags);
        end
      end
    end
  end

  // Remember exactly what a read returned; only those bits are cleared,
  // so an event landing after the capture is kept
  always_comb begin
    nxt_snap_main = snap_main_ff;
    nxt_snap_tf   = snap_tf_ff;
    nxt_snap_err  = snap_err_ff;
    if (setup) begin
      nxt_snap_main = FLAG_RST;
      nxt_snap_tf   = FLAG_RST;
      nxt_snap_err  = FLAG_RST;
      if (!pwrite_i && addr_hit(paddr_i, IDX_MAIN_FLAGS)) begin
        nxt_snap_main = summary & MAIN_FLAG_LATCH; // [RULE9]
      end
      if (!pwrite_i && addr_hit(paddr_i, IDX_TIMER_FLAGS)) begin
        nxt_snap_tf = tf_fl.flags; // [RULE10]
      end
      if (!pwrite_i && addr_hit(paddr_i, IDX_ERR_FLAGS)) begin
        nxt_snap_err = err_fl.flags; // [RULE10]
      end
    end
  end

  always_comb begin
    main_fl.clr = FLAG_RST;
    tf_fl.clr   = FLAG_RST;
    err_fl.clr  = FLAG_RST;
    if (access_done && !pwrite_i) begin
      main_fl.clr = snap_main_ff; // [RULE9]
      tf_fl.clr   = snap_tf_ff;
      err_fl.clr  = snap_err_ff;
    end
  end

  assign main_fl.sdef = sdef_ff; // [RULE11]
  assign tf_fl.sdef   = sdef_ff; // [RULE11]
  assign err_fl.sdef  = sdef_ff; // [RULE17]

  // Software-written registers; set-default lands one cycle after the write
  always_comb begin
    nxt_sdef      = wr_done & addr_hit(paddr_i, IDX_COMMAND) &
                    (wr_byte == CMD_SET_DEFAULT);
    nxt_main_mask = main_mask_ff;
    nxt_tf_mask   = tf_mask_ff;
    nxt_err_mask  = err_mask_ff;
    nxt_op_ctrl   = op_ctrl_ff;
    if (sdef_ff) begin
      nxt_main_mask = MASK_RST; // [RULE15]
      nxt_tf_mask   = MASK_RST; // [RULE16]
      nxt_err_mask  = MASK_RST; // [RULE2]
      nxt_op_ctrl   = OP_CTRL_RST;
    end else if (wr_done) begin
      if (addr_hit(paddr_i, IDX_MAIN_MASK)) begin
        nxt_main_mask = wr_byte & MAIN_MASK_USED; // [RULE15]
      end
      if (addr_hit(paddr_i, IDX_TIMER_MASK)) begin
        nxt_tf_mask = wr_byte; // [RULE16]
      end
      if (addr_hit(paddr_i, IDX_ERR_MASK)) begin
        nxt_err_mask = wr_byte; // [RULE1]
      end
      if (addr_hit(paddr_i, IDX_OP_CTRL)) begin
        nxt_op_ctrl = wr_byte;
      end
    end
  end

  // Level events are turned into one-cycle sets on their rising edge, field off on its falling edge
  assign wl_cond  = (rx_active_i & (fifo_count_i >= WL_FULL)) |  // [RULE5]
                    (tx_active_i & (fifo_count_i <= WL_EMPTY));  // [RULE6]
  assign cac_cond = ca_active_i & ext_field_i; // [RULE13]

  always_comb begin
    main_fl.set           = FLAG_RST;
    main_fl.set[MAIN_OSC] = op_ctrl_ff[OPC_EN] & osc_stable_i & ~osc_prev_ff; // [RULE4]
    main_fl.set[MAIN_WL]  = wl_cond & ~wl_prev_ff; // [RULE5] [RULE6]
    main_fl.set[MAIN_RXS] = rx_start_i;
    main_fl.set[MAIN_RXE] = rx_end_i;
    main_fl.set[MAIN_TXE] = tx_end_i;
    main_fl.set[MAIN_COL] = bit_col_i;
  end

  always_comb begin
    tf_fl.set          = FLAG_RST;
    tf_fl.set[TF_DCT]  = cmd_done_i; // [RULE12]
    tf_fl.set[TF_NRE]  = nrt_expire_i;
    tf_fl.set[TF_GPE]  = gpt_expire_i;
    tf_fl.set[TF_EON]  = ext_field_i & ~field_prev_ff;
    tf_fl.set[TF_EOF]  = ~ext_field_i & field_prev_ff;
    tf_fl.set[TF_CAC]  = cac_cond & ~cac_prev_ff; // [RULE13]
    tf_fl.set[TF_CAT]  = guard_done; // [RULE14]
    tf_fl.set[TF_NFCT] = bitrate_det_i;
  end

  assign err_fl.set = err_wake_evt_i; // [RULE17]

  // Masked flags still latch and show in their register; they stay
  // off the request line and out of the summary group bits
  always_comb begin
    nxt_irq = (|(main_fl.flags & ~main_mask_ff & MAIN_FLAG_LATCH)) |
              grp_tim | grp_err; // [RULE18] [RULE1] [RULE16]
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prdata_ff  <= RDATA_RST;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      snap_main_ff <= FLAG_RST;
      snap_tf_ff   <= FLAG_RST;
      snap_err_ff  <= FLAG_RST;
    end else begin
      snap_main_ff <= nxt_snap_main;
      snap_tf_ff   <= nxt_snap_tf;
      snap_err_ff  <= nxt_snap_err;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      main_mask_ff <= MASK_RST;
      tf_mask_ff   <= MASK_RST;
      err_mask_ff  <= MASK_RST; // [RULE2]
      op_ctrl_ff   <= OP_CTRL_RST;
      sdef_ff      <= 1'b0;
    end else begin
      main_mask_ff <= nxt_main_mask;
      tf_mask_ff   <= nxt_tf_mask;
      err_mask_ff  <= nxt_err_mask;
      op_ctrl_ff   <= nxt_op_ctrl;
      sdef_ff      <= nxt_sdef;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      osc_prev_ff   <= 1'b0;
      wl_prev_ff    <= 1'b0;
      field_prev_ff <= 1'b0;
      cac_prev_ff   <= 1'b0;
      irq_ff        <= 1'b0;
    end else begin
      osc_prev_ff   <= osc_stable_i;
      wl_prev_ff    <= wl_cond;
      field_prev_ff <= ext_field_i;
      cac_prev_ff   <= cac_cond;
      irq_ff        <= nxt_irq;
    end
  end

  assign prdata_o      = prdata_ff;
  assign pready_o      = pready_ff;
  assign pslverr_o     = pslverr_ff;
  assign osc_en_o      = op_ctrl_ff[OPC_EN];
  assign set_default_o = sdef_ff;
  assign irq_o         = irq_ff;

endmodule : riu_irq_unit
`default_nettype wire

// ===== verification/riu_irq_unit_sva.sv
// Port-level protocol and interrupt checks of the flag and mask unit
`timescale 1ns/1ps
`default_nettype none
module riu_irq_unit_sva
  import riu_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [DATA_W-1:0] pwdata_i,
  input  wire logic [DATA_W-1:0] prdata_o,
  input  wire logic              pready_o,
  input  wire logic              pslverr_o,
  input  wire logic              osc_en_o,
  input  wire logic              set_default_o,
  input  wire logic              irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic acc;
  assign acc = psel_i && penable_i && pready_o;

  rdy_after_setup_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  rdy_one_cycle_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  err_with_rdy_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  bad_addr_err_a: assert property (psel_i && !penable_i && paddr_i[1:0] != 2'h0 |=> pslverr_o)
    else $error("misaligned access not refused");
  high_zero_a: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  osc_en_wr_a: assert property (acc && pwrite_i && paddr_i == 8'h08
    |=> osc_en_o == $past(pwdata_i[OPC_EN]))
    else $error("oscillator enable not written");
  sdef_clear_a: assert property (acc && pwrite_i && paddr_i == 8'hc0 &&
    pwdata_i[7:0] == CMD_SET_DEFAULT |-> ##1 set_default_o ##1 (!set_default_o && !osc_en_o))
    else $error("set default not executed");
  irq_hold_a: assert property ($fell(irq_o) |-> $past(acc, 2) || $past(set_default_o, 2))
    else $error("interrupt dropped without clearing access");
endmodule : riu_irq_unit_sva
`default_nettype wire

// ===== verification/riu_mcu_model.sv
// Controller model: APB master that reads flags and writes masks
`timescale 1ns/1ps
`default_nettype none
module riu_mcu_model
  import riu_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic [DATA_W-1:0] prdata_i,
  input  wire logic              pready_i,
  input  wire logic              pslverr_i,
  output logic                   psel_o,
  output logic                   penable_o,
  output logic                   pwrite_o,
  output logic      [ADDR_W-1:0] paddr_o,
  output logic      [DATA_W-1:0] pwdata_o
);
  logic [DATA_W-1:0] rdat;
  logic              rerr;
  logic              tmo = 1'b0;
  int                idle = 0;
  int                n;
  initial psel_o = 1'b0;
  initial penable_o = 1'b0;
  initial pwrite_o = 1'b0;
  initial paddr_o = '0;
  initial pwdata_o = '0;

  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    repeat (idle) @(posedge clk_i);
    @(posedge clk_i);
    psel_o    <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o  <= w;
    paddr_o   <= a;
    // Reads carry junk write data so a slave that uses it shows up
    pwdata_o  <= w ? d : ~pwdata_o;
    @(posedge clk_i);
    penable_o <= 1'b1;
    n = 0;
    // Ready is sampled at the rising edge; the access ends at that edge
    do begin
      @(posedge clk_i);
      n++;
    end while (!pready_i && n < 64);
    tmo  = tmo | !pready_i;
    rdat = prdata_i;
    rerr = pslverr_i;
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
  endtask : xfer

  // Summary first, then each detail bank whose group bit is up
  task automatic isr(output logic [7:0] s, output logic [7:0] t, output logic [7:0] e);
    xfer(1'b0, 8'h5c, '0);
    s = rdat[7:0];
    t = 8'h00;
    e = 8'h00;
    if (s[MAIN_TIM]) begin
      xfer(1'b0, 8'h60, '0);
      t = rdat[7:0];
    end
    if (s[MAIN_ERR]) begin
      xfer(1'b0, 8'h64, '0);
      e = rdat[7:0];
    end
  endtask : isr
endmodule : riu_mcu_model
`default_nettype wire

// ===== verification/riu_irq_unit_tb_top.sv
// Self-checking testbench of the reader interrupt flag and mask unit
`timescale 1ns/1ps
`default_nettype none
module riu_irq_unit_tb_top;
  import riu_pkg::*;
  localparam int unsigned GCYC = 8;
  logic              clk_i = 1'b0;
  logic              rst_n_i = 1'b0;
  logic              psel, penable, pwrite, pready, pslverr;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata;
  logic              osc_st, rx_act, tx_act, ext_f, ca_act, ca_on;
  logic [6:0]        fcnt;
  logic [15:0]       ev;
  logic              osc_en, sdef, irq;
  logic [7:0]        s, t, e, m;
  logic [7:0]        tbit [4] = '{8'h01, 8'h20, 8'h40, 8'h80};
  logic [6:0]        wl [4] = '{WL_FULL - 7'h01, WL_FULL, WL_EMPTY + 7'h01, WL_EMPTY};
  integer            seed = 32'hb80d4492;
  int                miscompares = 0;
  int                samples_checked = 0;
  int                i;

  always #20 clk_i = ~clk_i;

  riu_mcu_model i_mcu (.clk_i(clk_i), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata));

  riu_irq_unit #(.GUARD_CYC(GCYC)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .osc_stable_i(osc_st), .rx_active_i(rx_act), .tx_active_i(tx_act), .fifo_count_i(fcnt),
    .rx_start_i(ev[3]), .rx_end_i(ev[2]), .tx_end_i(ev[1]), .bit_col_i(ev[0]),
    .cmd_done_i(ev[7]), .nrt_expire_i(ev[6]), .gpt_expire_i(ev[5]), .ext_field_i(ext_f),
    .ca_active_i(ca_act), .ca_field_on_i(ca_on), .bitrate_det_i(ev[4]),
    .err_wake_evt_i(ev[15:8]), .osc_en_o(osc_en), .set_default_o(sdef), .irq_o(irq));

  function automatic logic hit(input logic [7:0] f, input logic [7:0] msk);
    return |(f & ~msk);
  endfunction : hit

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [31:0] x);
    i_mcu.xfer(1'b0, a, '0);
    chk(i_mcu.rdat, x);
  endtask : rchk

  task automatic pulse(input logic [15:0] v);
    @(posedge clk_i);
    ev <= v;
    @(posedge clk_i);
    ev <= '0;
  endtask : pulse

  task summarize;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    summarize();
  end

  initial begin
    {osc_st, rx_act, tx_act, ext_f, ca_act, ca_on, fcnt, ev} = '0;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (i = 0; i < 6; i++) rchk(8'h50 + 8'(4 * i), 32'h0);
    for (i = 0; i < 3; i++) begin
      m = 8'($random(seed));
      i_mcu.idle = $unsigned($random(seed)) % 4;
      i_mcu.xfer(1'b1, 8'h50 + 8'(4 * i), {24'h0, m});
      rchk(8'h50 + 8'(4 * i), {24'h0, (i == 0) ? m & MAIN_MASK_USED : m});
    end
    i_mcu.idle = 0;
    i_mcu.xfer(1'b1, 8'h08, 32'h80);
    pulse(16'h0080);
    i_mcu.xfer(1'b1, 8'hc0, {24'h0, CMD_SET_DEFAULT});
    // Give the command three cycles before reading the cleared banks
    repeat (3) @(posedge clk_i);
    chk(osc_en, 0);
    for (i = 0; i < 6; i++) rchk(8'h50 + 8'(4 * i), 32'h0);
    i_mcu.xfer(1'b0, 8'h71, '0);
    chk(i_mcu.rerr, 1);
    chk(i_mcu.rdat, 0);
    i_mcu.xfer(1'b1, 8'h5c, 32'hff);
    rchk(8'h5c, 32'h0);
    for (i = 0; i < 4; i++) begin
      pulse(16'h1 << i);
      @(posedge clk_i);
      #1 chk(irq, 1);
      rchk(8'h5c, 32'h4 << i);
      rchk(8'h5c, 32'h0);
      chk(irq, 0);
    end
    for (i = 0; i < 4; i++) begin
      pulse(16'h10 << i);
      rchk(8'h5c, 32'h2);
      rchk(8'h5c, 32'h2);
      rchk(8'h60, {24'h0, tbit[i]});
      rchk(8'h5c, 32'h0);
    end
    for (i = 0; i < 4; i++) begin
      e = 8'($random(seed)) | 8'h01;
      m = (i == 0) ? 8'hff : 8'($random(seed));
      i_mcu.xfer(1'b1, 8'h58, {24'h0, m});
      pulse({e, 8'h00});
      @(posedge clk_i);
      #1 chk(irq, hit(e, m));
      rchk(8'h5c, {31'h0, hit(e, m)});
      rchk(8'h64, {24'h0, e});
      rchk(8'h5c, 32'h0);
    end
    i_mcu.xfer(1'b1, 8'h58, 32'h0);
    rchk(8'h5c, 32'h0);
    i_mcu.xfer(1'b1, 8'h08, 32'h80);
    osc_st <= 1'b1;
    rchk(8'h5c, 32'h80);
    for (i = 0; i < 4; i++) begin
      @(posedge clk_i);
      rx_act <= (i < 2);
      tx_act <= (i >= 2);
      fcnt   <= wl[i];
      rchk(8'h5c, (i % 2) ? 32'h40 : 32'h0);
    end
    {rx_act, tx_act, fcnt} <= '0;
    ca_act <= 1'b1;
    ext_f  <= 1'b1;
    i_mcu.isr(s, t, e);
    chk({s, t}, 16'h0214);
    ca_act <= 1'b0;
    ext_f  <= 1'b0;
    i_mcu.isr(s, t, e);
    chk({s, t}, 16'h0208);
    @(posedge clk_i);
    ca_on <= 1'b1;
    @(posedge clk_i);
    ca_on <= 1'b0;
    repeat (GCYC + 1) @(posedge clk_i);
    #1 chk(irq, 0);
    @(posedge clk_i);
    #1 chk(irq, 1);
    rchk(8'h60, 32'h2);
    fork
      rchk(8'h5c, 32'h0);
      begin
        repeat (2) @(posedge clk_i);
        ev <= 16'h0004;
        @(posedge clk_i);
        ev <= '0;
      end
    join
    rchk(8'h5c, 32'h10);
    if (i_mcu.tmo) miscompares++;
    summarize();
  end
endmodule : riu_irq_unit_tb_top

bind riu_irq_unit riu_irq_unit_sva i_sva (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .osc_en_o(osc_en_o), .set_default_o(set_default_o), .irq_o(irq_o));
`default_nettype wire
